// [design/key_scan_pkg.sv]
// key scan handshake constants: oscillator timing and key field widths
// assumes a 125 MHz core clock and an oscillator period derived from it
package key_scan_pkg;
    // ----------------------------------------
    // key data layout
    // ----------------------------------------
    localparam int unsigned KEY_BITS      = 30;
    localparam logic [7:0]  KEY_READ_ADDR = 8'h43;
    // ----------------------------------------
    // timing in oscillator periods (T)
    // ----------------------------------------
    localparam int unsigned SCAN_SHORT_T  = 4800;
    localparam int unsigned SCAN_LONG_T   = 9600;
    localparam int unsigned SCAN_PASS_T   = SCAN_SHORT_T / 2;
    // core cycles per oscillator period, plain default
    localparam int unsigned OSC_DIV       = 125;
    localparam int unsigned OSC_CNT_W     = 16;
    localparam int unsigned PASS_CNT_W    = 16;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [29:0] KEY_RST       = 30'h0000_0000;
    localparam logic [1:0]  PASS_RST      = 2'h0;
endpackage

// [design/osc_tick_gen.sv]
// oscillator period generator: one-cycle tick every DIV core clocks
// assumes a synchronous active-high clear from the enclosing block
`timescale 1ns/10ps
`default_nettype none
module osc_tick_gen #(
    parameter int unsigned DIV = key_scan_pkg::OSC_DIV
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clr,
    output logic      tick
);
    // ----------------------------------------
    // divider
    // ----------------------------------------
    logic [key_scan_pkg::OSC_CNT_W-1:0] cnt_q;
    logic [key_scan_pkg::OSC_CNT_W-1:0] cnt_d;
    logic                                wrap;

    assign wrap  = (cnt_q == key_scan_pkg::OSC_CNT_W'(DIV - 1));
    assign cnt_d = (clr || wrap) ? '0 : cnt_q + 1'b1;
    assign tick  = wrap && !clr;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule // osc_tick_gen
`default_nettype wire

// [design/key_scan_irq.sv]
// key scanner with interrupt-style data-ready signalling on the serial output
// assumes serial framing logic outside gives read start/done pulses on core_clk
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - when two scans agree the scan finishes after exactly 4800 oscillator periods.
// - when two scans disagree the scan repeats and finishes after 9600 periods.
// - a pressed key with ready data drives the serial output low while chip enable is low.
// - a read made while the serial output is high returns data flagged invalid.
module key_scan_irq #(
    parameter int unsigned OSC_DIV    = key_scan_pkg::OSC_DIV,
    parameter int unsigned PASS_TICKS = key_scan_pkg::SCAN_PASS_T
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [29:0] key_in,
    input  wire logic        ce_n,
    input  wire logic        sleep_mode,
    input  wire logic        key_read_start,
    input  wire logic        key_read_done,
    output logic             do_out,
    output logic             do_oe,
    output logic [29:0]      key_state_bits,
    output logic             sleep_ack_bit,
    output logic             key_data_valid,
    output logic             scan_busy
);
    // ----------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------
    logic        rst_s1_q, rst_q_n;
    logic [29:0] key_s1_q, key_s2_q;
    logic        ce_s1_q, ce_s2_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_q <= 1'b0;
            rst_q_n  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q_n  <= rst_s1_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            key_s1_q <= key_scan_pkg::KEY_RST;
            key_s2_q <= key_scan_pkg::KEY_RST;
            ce_s1_q  <= 1'b1;
            ce_s2_q  <= 1'b1;
        end else begin
            key_s1_q <= key_in;
            key_s2_q <= key_s1_q;
            ce_s1_q  <= ce_n;
            ce_s2_q  <= ce_s1_q;
        end
    end

    // ----------------------------------------
    // oscillator period
    // ----------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_HOLD} scan_state_t;
    scan_state_t state_q, state_d;
    logic        osc_tick;

    osc_tick_gen #(.DIV(OSC_DIV)) u_osc (
        .clk   (core_clk),
        .rst_n (rst_q_n),
        .clr   (state_q != ST_SCAN),
        .tick  (osc_tick)
    );

    // ----------------------------------------
    // scan sequencing
    // ----------------------------------------
    logic [key_scan_pkg::PASS_CNT_W-1:0] tick_cnt_q, tick_cnt_d;
    logic [1:0]  pass_q, pass_d;
    logic [29:0] sample_q, sample_d;
    logic [29:0] keys_q, keys_d;
    logic        ready_q, ready_d;
    logic        valid_q, valid_d;
    logic        sa_q, sa_d;
    logic        reading_q, reading_d;
    logic        any_key, pass_end, agree, scan_done;

    assign any_key   = |key_s2_q;
    assign pass_end  = (state_q == ST_SCAN) && osc_tick &&
                       (tick_cnt_q == key_scan_pkg::PASS_CNT_W'(PASS_TICKS - 1));
    assign agree     = (sample_q == key_s2_q);
    // pass 1 ends the scan on agreement, pass 3 always ends it
    assign scan_done = pass_end && ((pass_q == 2'h1 && agree) || pass_q == 2'h3);

    always_comb begin
        state_d    = state_q;
        tick_cnt_d = tick_cnt_q;
        pass_d     = pass_q;
        sample_d   = sample_q;
        keys_d     = keys_q;
        ready_d    = ready_q;
        unique case (state_q)
            ST_IDLE: begin
                if (any_key) begin
                    state_d    = ST_SCAN;
                    tick_cnt_d = '0;
                    pass_d     = key_scan_pkg::PASS_RST;
                end
            end
            ST_SCAN: begin
                if (osc_tick) begin
                    tick_cnt_d = pass_end ? '0 : tick_cnt_q + 1'b1;
                end
                if (scan_done) begin
                    keys_d  = key_s2_q;
                    state_d = ST_HOLD;
                end else if (pass_end) begin
                    sample_d = key_s2_q;
                    pass_d   = pass_q + 2'h1;
                end
            end
            ST_HOLD: begin
                if (!reading_q && !ready_q && !any_key) begin
                    state_d = ST_IDLE;
                end else if (!reading_q && !ready_q) begin
                    state_d    = ST_SCAN;
                    tick_cnt_d = '0;
                    pass_d     = key_scan_pkg::PASS_RST;
                end
            end
        endcase
        // new data beat a read completion in the same cycle
        if (key_read_done) begin
            ready_d = 1'b0;
        end
        if (scan_done) begin
            ready_d = 1'b1;
        end
    end

    // ----------------------------------------
    // read capture
    // ----------------------------------------
    assign reading_d = key_read_start ? 1'b1 : (key_read_done ? 1'b0 : reading_q);
    // data taken with the output high is marked invalid
    assign valid_d   = key_read_start ? (ready_q && !ce_s2_q) : valid_q;
    assign sa_d      = key_read_start ? sleep_mode : sa_q;

    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            state_q    <= ST_IDLE;
            tick_cnt_q <= '0;
            pass_q     <= key_scan_pkg::PASS_RST;
            sample_q   <= key_scan_pkg::KEY_RST;
            keys_q     <= key_scan_pkg::KEY_RST;
            ready_q    <= 1'b0;
            valid_q    <= 1'b0;
            sa_q       <= 1'b0;
            reading_q  <= 1'b0;
        end else begin
            state_q    <= state_d;
            tick_cnt_q <= tick_cnt_d;
            pass_q     <= pass_d;
            sample_q   <= sample_d;
            keys_q     <= keys_d;
            ready_q    <= ready_d;
            valid_q    <= valid_d;
            sa_q       <= sa_d;
            reading_q  <= reading_d;
        end
    end

    // ----------------------------------------
    // serial output and user outputs
    // ----------------------------------------
    logic do_out_q, do_oe_q, busy_q;
    logic [29:0] kd_q;
    logic        do_oe_d, do_out_d;

    assign do_oe_d  = !ce_s2_q && !reading_q;
    assign do_out_d = !ready_q;

    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            do_out_q <= 1'b1;
            do_oe_q  <= 1'b0;
            busy_q   <= 1'b0;
            kd_q     <= key_scan_pkg::KEY_RST;
        end else begin
            do_out_q <= do_out_d;
            do_oe_q  <= do_oe_d;
            busy_q   <= (state_q == ST_SCAN);
            kd_q     <= key_read_start ? keys_q : kd_q;
        end
    end

    assign do_out         = do_out_q;
    assign do_oe          = do_oe_q;
    assign key_state_bits = kd_q;
    assign sleep_ack_bit  = sa_q;
    assign key_data_valid = valid_q;
    assign scan_busy      = busy_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [15:0] scan_ticks_q;
    always_ff @(posedge core_clk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            scan_ticks_q <= '0;
        end else if (state_q != ST_SCAN) begin
            scan_ticks_q <= '0;
        end else if (osc_tick) begin
            scan_ticks_q <= scan_ticks_q + 16'h0001;
        end
    end

    property p_short_scan;
        @(posedge core_clk) disable iff (!rst_q_n)
        (scan_done && pass_q == 2'h1) |-> (scan_ticks_q == 16'(2 * PASS_TICKS - 1));
    endproperty
    a_short_scan: assert property (p_short_scan) else $error("agreeing scan length wrong");

    property p_long_scan;
        @(posedge core_clk) disable iff (!rst_q_n)
        (scan_done && pass_q == 2'h3) |-> (scan_ticks_q == 16'(4 * PASS_TICKS - 1));
    endproperty
    a_long_scan: assert property (p_long_scan) else $error("repeated scan length wrong");

    property p_do_low_ready;
        @(posedge core_clk) disable iff (!rst_q_n)
        scan_done |=> ##1 (!do_out);
    endproperty
    a_do_low_ready: assert property (p_do_low_ready) else $error("output not low after scan");

    property p_do_high_scan;
        @(posedge core_clk) disable iff (!rst_q_n)
        (state_q == ST_SCAN && !ready_q) [*2] |-> do_out;
    endproperty
    a_do_high_scan: assert property (p_do_high_scan) else $error("output low during scan");

    property p_invalid_read;
        @(posedge core_clk) disable iff (!rst_q_n)
        (key_read_start && !ready_q) |=> !key_data_valid;
    endproperty
    a_invalid_read: assert property (p_invalid_read) else $error("read marked valid wrongly");

    property p_oe_ce;
        @(posedge core_clk) disable iff (!rst_q_n)
        ce_s2_q |=> !do_oe;
    endproperty
    a_oe_ce: assert property (p_oe_ce) else $error("output driven with chip enable high");

    c_short: cover property (@(posedge core_clk) disable iff (!rst_q_n)
        scan_done && pass_q == 2'h1);
    c_long: cover property (@(posedge core_clk) disable iff (!rst_q_n)
        scan_done && pass_q == 2'h3);
    c_valid_read: cover property (@(posedge core_clk) disable iff (!rst_q_n)
        key_read_start && ready_q && !ce_s2_q);
endmodule // key_scan_irq
`default_nettype wire

// [bench/host_model.sv]
// host stand-in: holds chip enable, watches the data line, runs key reads
// assumes the scanner's core clock and one-cycle read pulses
`timescale 1ns/10ps
`default_nettype none
module host_model #(
    parameter int unsigned RECHECK = 40
) (
    input  wire logic       core_clk,
    input  wire logic       en,
    input  wire logic       auto_rd,
    input  wire logic       force_rd,
    input  wire logic       do_out,
    input  wire logic       do_oe,
    output logic            ce_n,
    output logic            key_read_start,
    output logic            key_read_done,
    output logic [7:0]      rd_cnt
);
    // --------
    // data line as the host sees it
    // --------
    logic do_last = 1'h1;
    wire  do_line = do_oe ? do_out : ~do_last;
    always @(posedge core_clk) do_last <= do_line;
    always @(posedge core_clk) ce_n <= ~en;
    // --------
    // read sequence
    // --------
    initial begin
        key_read_start = 1'h0;
        key_read_done = 1'h0;
        rd_cnt = 8'h00;
        forever begin
            @(posedge core_clk);
            if (force_rd || (auto_rd && !ce_n && do_line === 1'h0)) begin
                key_read_start <= 1'h1;
                @(posedge core_clk);
                key_read_start <= 1'h0;
                repeat (8) @(posedge core_clk);
                key_read_done <= 1'h1;
                @(posedge core_clk);
                key_read_done <= 1'h0;
                rd_cnt <= rd_cnt + 8'h01;
                repeat (RECHECK) @(posedge core_clk);
            end
        end
    end
endmodule // host_model
`default_nettype wire

// [bench/tb_top.sv]
// bench for the key scanner: agreed and repeated scans, valid and invalid reads
// assumes the host stand-in drives chip enable and the read pulses
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // --------
    // setup
    // --------
    localparam int unsigned DIV   = 2;
    localparam int unsigned PT    = 4;
    localparam int unsigned SHORT = 2 * PT * DIV;
    localparam int unsigned LONG  = 4 * PT * DIV;
    logic        core_clk   = 1'h0;
    logic        rst_n      = 1'h0;
    logic [29:0] key_in     = 30'h0;
    logic        sleep_mode = 1'h0;
    logic        en         = 1'h0;
    logic        auto_rd    = 1'h0;
    logic        force_rd   = 1'h0;
    logic        ce_n, key_read_start, key_read_done, do_out, do_oe;
    logic [29:0] key_state_bits;
    logic        sleep_ack_bit, key_data_valid, scan_busy;
    logic [7:0]  rd_cnt;
    int          error_cnt  = 0;
    int          compares   = 0;
    int          n;
    always #4 core_clk = ~core_clk;
    key_scan_irq #(.OSC_DIV(DIV), .PASS_TICKS(PT)) key_scan_irq_inst (
        .core_clk(core_clk), .rst_n(rst_n), .key_in(key_in), .ce_n(ce_n),
        .sleep_mode(sleep_mode), .key_read_start(key_read_start),
        .key_read_done(key_read_done), .do_out(do_out), .do_oe(do_oe),
        .key_state_bits(key_state_bits), .sleep_ack_bit(sleep_ack_bit),
        .key_data_valid(key_data_valid), .scan_busy(scan_busy));
    host_model #(.RECHECK(LONG + 8)) host_model_inst (
        .core_clk(core_clk), .en(en), .auto_rd(auto_rd), .force_rd(force_rd),
        .do_out(do_out), .do_oe(do_oe), .ce_n(ce_n), .key_read_start(key_read_start),
        .key_read_done(key_read_done), .rd_cnt(rd_cnt));
    // --------
    // helpers
    // --------
    task automatic give_verdict();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [29:0] exp, input logic [29:0] got);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge core_clk);
        #1;
    endtask
    task automatic wait_for(input string what, input logic lvl, input int lim);
        n = 0;
        while (do_out !== lvl) begin
            tick(1);
            n++;
            if (n > lim) begin
                chk(what, 30'(lvl), 30'(do_out));
                give_verdict();
            end
        end
    endtask
    task automatic run_read(input logic frc, input logic [29:0] exp, input logic vld);
        @(posedge core_clk);
        force_rd <= frc;
        auto_rd  <= ~frc;
        @(posedge core_clk);
        force_rd <= 1'h0;
        #1;
        n = 0;
        while (key_read_start !== 1'h1) begin
            tick(1);
            n++;
            if (n > 60) begin
                chk("read_start", 30'h1, 30'(key_read_start));
                give_verdict();
            end
        end
        @(posedge core_clk);
        key_in  <= 30'h0;
        auto_rd <= 1'h0;
        tick(1);
        if (vld)
            chk("key_state_bits", exp, key_state_bits);
        chk("key_data_valid", 30'(vld), 30'(key_data_valid));
        chk("sleep_ack_bit", 30'(sleep_mode), 30'(sleep_ack_bit));
        tick(12);
        wait_for("do_out_after_read", 1'h1, 4);
    endtask
    // --------
    // scenarios
    // --------
    task automatic scan_agree();
        @(posedge core_clk);
        sleep_mode <= 1'h1;
        key_in     <= 30'h5;
        tick(SHORT);
        chk("do_out_scan", 30'h1, 30'(do_out));
        chk("scan_busy", 30'h1, 30'(scan_busy));
        wait_for("do_out_ready", 1'h0, 10);
        chk("do_oe_ready", 30'h1, 30'(do_oe));
        run_read(1'h0, 30'h5, 1'h1);
    endtask
    task automatic scan_disagree();
        @(posedge core_clk);
        key_in <= 30'h30;
        repeat (7) @(posedge core_clk);
        key_in <= 30'h300;
        repeat (8) @(posedge core_clk);
        key_in <= 30'h2000_0001;
        tick(SHORT - 7);
        chk("do_out_rescan", 30'h1, 30'(do_out));
        wait_for("do_out_rescan_end", 1'h0, LONG);
        run_read(1'h0, 30'h2000_0001, 1'h1);
    endtask
    task automatic read_invalid();
        @(posedge core_clk);
        sleep_mode <= 1'h0;
        tick(LONG + 8);
        chk("do_out_idle", 30'h1, 30'(do_out));
        chk("scan_busy_idle", 30'h0, 30'(scan_busy));
        run_read(1'h1, 30'h0, 1'h0);
        @(posedge core_clk);
        en <= 1'h0;
        tick(6);
        chk("do_oe_ce_high", 30'h0, 30'(do_oe));
    endtask
    initial begin
        tick(15);
        chk("do_out_rst", 30'h1, 30'(do_out));
        chk("do_oe_rst", 30'h0, 30'(do_oe));
        @(posedge core_clk);
        rst_n <= 1'h1;
        en    <= 1'h1;
        tick(8);
        chk("do_oe_idle", 30'h1, 30'(do_oe));
        scan_agree();
        scan_disagree();
        read_invalid();
        chk("rd_cnt", 30'h3, 30'(rd_cnt));
        give_verdict();
    end
endmodule // tb_top
`default_nettype wire
